// >>> trv_pkg.sv
// constants, field layouts and carrier types for the timer reload and channel value block
// assumes a single 20 MHz sys_clk and a plain one-cycle register port
// ****************************************************************
package trv_pkg;
    localparam int unsigned CHAN_NUM = 4;
    localparam logic [7:0] OFF_RELOAD = 8'h2c;
    localparam logic [7:0] OFF_CHAN0 = 8'h34;
    localparam logic [7:0] OFF_CHAN1 = 8'h38;
    localparam logic [7:0] OFF_CHAN2 = 8'h3c;
    localparam logic [7:0] OFF_CHAN3 = 8'h40;
    // block-local control and status
    localparam logic [7:0] OFF_CTRL = 8'h80;
    localparam logic [7:0] OFF_STAT = 8'h84;
    // control field positions, one bit per channel in each nibble
    localparam int unsigned CTRL_ENABLE_LSB = 0;
    localparam int unsigned CTRL_INPUT_LSB = 4;
    localparam int unsigned CTRL_SHADOW_LSB = 8;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;
    localparam logic [11:0] CTRL_RESET = 12'h000;
    localparam logic [31:0] READ_UNMAPPED = 32'h0000_0000;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } trv_bus_req_t;

    typedef struct packed {
        logic enable;
        logic input_mode;
        logic shadow_en;
    } trv_chan_cfg_t;

    typedef enum logic [1:0] {
        TRV_IDLE,
        TRV_READ
    } trv_rd_state_t;
endpackage

// >>> trv_decode.sv
// address decode for the register port
// assumes word aligned byte offsets from the package
`timescale 1ns/1ps
module trv_decode (
    // address
    input wire logic [7:0] addr,
    // one-hot selects
    output logic sel_reload,
    output logic [3:0] sel_chan,
    output logic sel_ctrl,
    output logic sel_stat
);
    always_comb begin
        sel_reload = (addr == trv_pkg::OFF_RELOAD);
        sel_chan[0] = (addr == trv_pkg::OFF_CHAN0);
        sel_chan[1] = (addr == trv_pkg::OFF_CHAN1);
        sel_chan[2] = (addr == trv_pkg::OFF_CHAN2);
        sel_chan[3] = (addr == trv_pkg::OFF_CHAN3);
        sel_ctrl = (addr == trv_pkg::OFF_CTRL);
        sel_stat = (addr == trv_pkg::OFF_STAT);
    end
endmodule

// >>> trv_channel.sv
// one capture/compare value channel with optional shadow copy
// assumes counter, capture and update strobes are synchronous to sys_clk
`timescale 1ns/1ps
module trv_channel (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // configuration
    input wire trv_pkg::trv_chan_cfg_t cfg,
    // software write
    input wire logic wr_en,
    input wire logic [31:0] wdata,
    // timer events
    input wire logic [31:0] counter,
    input wire logic capture,
    input wire logic update,
    // state
    output logic [31:0] value,
    output logic [31:0] active,
    output logic match
);
    logic [31:0] value_r;
    logic [31:0] value_nxt;
    logic [31:0] active_r;
    logic [31:0] active_nxt;
    logic match_r;
    logic match_nxt;

    always_comb begin
        value_nxt = value_r;
        active_nxt = active_r;
        if (cfg.input_mode) begin
            // capture wins; writes never land in input mode
            if (capture && cfg.enable) begin
                value_nxt = counter;
            end
        end else if (wr_en) begin
            value_nxt = wdata;
        end
        // shadow off means the written value is live at once
        if (!cfg.shadow_en) begin
            active_nxt = value_nxt;
        end else if (update) begin
            active_nxt = value_r;
        end
        match_nxt = !cfg.input_mode && (counter == active_r);
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            value_r <= trv_pkg::RESET_WORD;
            active_r <= trv_pkg::RESET_WORD;
            match_r <= 1'b0;
        end else begin
            value_r <= value_nxt;
            active_r <= active_nxt;
            match_r <= match_nxt;
        end
    end

    assign value = value_r;
    assign active = active_r;
    assign match = match_r;

    ro_input_a: assert property (@(posedge sys_clk) disable iff (rst)
        cfg.input_mode && !(capture && cfg.enable) |=> $stable(value_r))
        else $error("input mode value changed without capture");
    cap_load_a: assert property (@(posedge sys_clk) disable iff (rst)
        cfg.input_mode && capture && cfg.enable |=> value_r == $past(counter))
        else $error("capture did not load counter");
    cap_gate_a: assert property (@(posedge sys_clk) disable iff (rst)
        cfg.input_mode && !cfg.enable |=> $stable(value_r))
        else $error("capture taken while disabled");
    out_write_a: assert property (@(posedge sys_clk) disable iff (rst)
        !cfg.input_mode && wr_en |=> value_r == $past(wdata))
        else $error("compare write lost");
    shadow_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
        cfg.shadow_en && !update ##1 cfg.shadow_en |-> $stable(active_r))
        else $error("shadow changed without update");
    shadow_load_a: assert property (@(posedge sys_clk) disable iff (rst)
        cfg.shadow_en && update |=> active_r == $past(value_r))
        else $error("shadow missed update");
    cap_seen_c: cover property (@(posedge sys_clk) cfg.input_mode && capture && cfg.enable);
    shadow_seen_c: cover property (@(posedge sys_clk) cfg.shadow_en && wr_en ##[1:8] update);
    match_seen_c: cover property (@(posedge sys_clk) match_r);
endmodule

// >>> trv_top.sv
// top of the timer reload and channel value block
// assumes a synchronous register port with read data one cycle after the read strobe
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
module trv_top (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // timer kernel
    input wire logic [31:0] counter,
    input wire logic [3:0] capture,
    input wire logic update,
    // to the kernel
    output logic [31:0] reload_limit,
    output logic [3:0] compare_match
);
    // ****************************************************************
    // register access
    // ****************************************************************
    trv_pkg::trv_bus_req_t req;
    logic sel_reload;
    logic [3:0] sel_chan;
    logic sel_ctrl;
    logic sel_stat;
    logic [31:0] reload_r;
    logic [31:0] reload_nxt;
    logic [11:0] ctrl_r;
    logic [11:0] ctrl_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic [31:0] chan_value [4];
    logic [31:0] chan_active [4];
    logic [3:0] chan_match;
    logic [3:0] match_r;

    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

    trv_decode u_decode (
        .addr(req.addr),
        .sel_reload(sel_reload),
        .sel_chan(sel_chan),
        .sel_ctrl(sel_ctrl),
        .sel_stat(sel_stat)
    );

    always_comb begin
        reload_nxt = reload_r;
        ctrl_nxt = ctrl_r;
        if (req.wr && sel_reload) begin
            reload_nxt = req.wdata;
        end
        if (req.wr && sel_ctrl) begin
            ctrl_nxt = req.wdata[11:0];
        end
        // whole word only; no byte lanes exist on this port
        rdata_nxt = trv_pkg::READ_UNMAPPED;
        if (req.rd) begin
            if (sel_reload) begin
                rdata_nxt = reload_r;
            end else if (sel_ctrl) begin
                rdata_nxt = {20'h00000, ctrl_r};
            end else if (sel_stat) begin
                rdata_nxt = {28'h0000000, match_r};
            end else begin
                for (int i = 0; i < 4; i++) begin
                    if (sel_chan[i]) begin
                        rdata_nxt = chan_value[i];
                    end
                end
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            reload_r <= trv_pkg::RESET_WORD;
            ctrl_r <= trv_pkg::CTRL_RESET;
            rdata_r <= trv_pkg::RESET_WORD;
            match_r <= 4'h0;
        end else begin
            reload_r <= reload_nxt;
            ctrl_r <= ctrl_nxt;
            rdata_r <= rdata_nxt;
            match_r <= chan_match;
        end
    end

    // ****************************************************************
    // channels
    // ****************************************************************
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_chan
            trv_pkg::trv_chan_cfg_t cfg;
            // one driver for the whole struct, not one per field
            assign cfg = '{
                enable: ctrl_r[trv_pkg::CTRL_ENABLE_LSB + g],
                input_mode: ctrl_r[trv_pkg::CTRL_INPUT_LSB + g],
                shadow_en: ctrl_r[trv_pkg::CTRL_SHADOW_LSB + g]
            };
            trv_channel u_chan (
                .sys_clk(sys_clk),
                .rst(rst),
                .cfg(cfg),
                .wr_en(req.wr && sel_chan[g]),
                .wdata(req.wdata),
                .counter(counter),
                .capture(capture[g]),
                .update(update),
                .value(chan_value[g]),
                .active(chan_active[g]),
                .match(chan_match[g])
            );
        end
    endgenerate

    assign reg_rdata = rdata_r;
    assign reload_limit = reload_r;
    assign compare_match = match_r;

    reload_write_a: assert property (@(posedge sys_clk) disable iff (rst)
        reg_wr && sel_reload |=> reload_limit == $past(reg_wdata))
        else $error("reload write lost");
    read_data_a: assert property (@(posedge sys_clk) disable iff (rst)
        reg_rd && sel_chan[0] && !capture[0] |=> reg_rdata == chan_value[0])
        else $error("channel read mismatch");
    // with the shadow off the compare copy must track the value register
    active_follow_a: assert property (@(posedge sys_clk) disable iff (rst)
        !ctrl_r[trv_pkg::CTRL_SHADOW_LSB] |=> chan_active[0] == chan_value[0])
        else $error("active copy lags the value register");
    reload_rd_c: cover property (@(posedge sys_clk) reg_wr && sel_reload ##1 reg_rd && sel_reload);
endmodule

// >>> tb_timer_reload_and_channel_values.sv
// self-checking testbench for the timer reload and channel value block
// assumes trv_pkg and trv_top are compiled first; the bench drives every port itself
`timescale 1ns/1ps
module tb_timer_reload_and_channel_values;
    // ****************************************************************
    // clock, reset and design
    // ****************************************************************
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic [31:0] counter = 32'h0000_0000;
    logic [3:0] capture = 4'h0;
    logic update = 1'b0;
    logic [31:0] reload_limit;
    logic [3:0] compare_match;
    int fail_count = 0;
    int num_checks = 0;

    always #25 sys_clk = ~sys_clk;

    trv_top u_trv_top (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .counter(counter), .capture(capture), .update(update),
        .reload_limit(reload_limit), .compare_match(compare_match));

    // ****************************************************************
    // shared tasks
    // ****************************************************************
    task automatic end_of_test();
        if (fail_count == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    // whole 32-bit words only on the register port
    task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic bus_read(input logic [7:0] a, input logic [31:0] exp);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        check(reg_rdata, exp);
    endtask

    // counter moves on after the pulse so a late sample would show
    task automatic pulse_capture(input logic [31:0] cnt, input logic [3:0] ch);
        @(posedge sys_clk);
        counter <= cnt;
        capture <= ch;
        @(posedge sys_clk);
        capture <= 4'h0;
        counter <= ~cnt;
    endtask

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic test_reset_values();
        bus_read(trv_pkg::OFF_RELOAD, trv_pkg::RESET_WORD);
        bus_read(trv_pkg::OFF_CHAN0, trv_pkg::RESET_WORD);
        bus_read(trv_pkg::OFF_CHAN1, trv_pkg::RESET_WORD);
        bus_read(trv_pkg::OFF_CHAN2, trv_pkg::RESET_WORD);
        bus_read(trv_pkg::OFF_CHAN3, trv_pkg::RESET_WORD);
        bus_read(8'h50, trv_pkg::READ_UNMAPPED);
    endtask

    task automatic test_reload();
        bus_write(trv_pkg::OFF_RELOAD, 32'hffff_ffff);
        settle(0);
        check(reload_limit, 32'hffff_ffff);
        bus_read(trv_pkg::OFF_RELOAD, 32'hffff_ffff);
        bus_write(trv_pkg::OFF_RELOAD, 32'h0000_0001);
        bus_read(trv_pkg::OFF_RELOAD, 32'h0000_0001);
    endtask

    task automatic test_output_compare();
        bus_write(trv_pkg::OFF_CHAN0, 32'h1234_5678);
        bus_read(trv_pkg::OFF_CHAN0, 32'h1234_5678);
        @(posedge sys_clk);
        counter <= 32'h1234_5678;
        settle(4);
        check({28'h0000000, compare_match}, 32'h0000_0001);
        @(posedge sys_clk);
        counter <= 32'h1234_5679;
        settle(4);
        check({28'h0000000, compare_match}, 32'h0000_0000);
    endtask

    task automatic test_capture();
        bus_write(trv_pkg::OFF_CTRL, 32'h0000_0022);
        pulse_capture(32'habcd_0001, 4'h2);
        bus_read(trv_pkg::OFF_CHAN1, 32'habcd_0001);
        bus_write(trv_pkg::OFF_CHAN1, 32'h1111_1111);
        bus_read(trv_pkg::OFF_CHAN1, 32'habcd_0001);
        bus_write(trv_pkg::OFF_CTRL, 32'h0000_0020);
        pulse_capture(32'h0000_0777, 4'h2);
        bus_read(trv_pkg::OFF_CHAN1, 32'habcd_0001);
    endtask

    // active copy must hold its old value until the update pulse
    task automatic test_shadow();
        bus_write(trv_pkg::OFF_CTRL, 32'h0000_0400);
        bus_write(trv_pkg::OFF_CHAN2, 32'h0000_0055);
        bus_read(trv_pkg::OFF_CHAN2, 32'h0000_0055);
        @(posedge sys_clk);
        counter <= 32'h0000_0055;
        settle(4);
        check({28'h0000000, compare_match}, 32'h0000_0000);
        @(posedge sys_clk);
        update <= 1'b1;
        @(posedge sys_clk);
        update <= 1'b0;
        settle(4);
        check({28'h0000000, compare_match}, 32'h0000_0004);
        bus_read(trv_pkg::OFF_STAT, 32'h0000_0004);
        bus_read(trv_pkg::OFF_CTRL, 32'h0000_0400);
    endtask

    // a reset in mid-run must bring the reload limit and control back to zero
    task automatic test_mid_reset();
        bus_write(trv_pkg::OFF_RELOAD, 32'ha5a5_a5a5);
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        settle(0);
        check(reload_limit, trv_pkg::RESET_WORD);
        bus_read(trv_pkg::OFF_CHAN2, trv_pkg::RESET_WORD);
        bus_read(trv_pkg::OFF_CTRL, {20'h00000, trv_pkg::CTRL_RESET});
    endtask

    // ****************************************************************
    // main sequence and watchdog
    // ****************************************************************
    initial begin
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        test_reset_values();
        test_reload();
        test_output_compare();
        test_capture();
        test_shadow();
        test_mid_reset();
        end_of_test();
    end

    initial begin
        repeat (5000) @(posedge sys_clk);
        fail_count++;
        end_of_test();
    end
endmodule
